//--- hw/door_service_button_control.sv
// Service button command interpreter: learn run, manual moves, force editor.
// Assumes one clk at 20 MHz, rst asserted at power-on, drive reports end
// positions and learn run step completion as same-clock levels/pulses.
`timescale 1ns/1ps
`default_nettype none
module door_service_button_control
   import door_svc_pkg::*;
#(
   parameter int unsigned LEARN_CYC   = LEARN_HOLD_CYC,
   parameter int unsigned STORE_CYC   = STORE_HOLD_CYC,
   parameter int unsigned SPLASH_LEN  = SPLASH_CYC,
   parameter int unsigned RELEASE_LEN = RELEASE_CYC,
   parameter int unsigned BLINK_LEN   = BLINK_CYC,
   parameter int unsigned DEB_CYC     = DEBOUNCE_CYC
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        learn_button,
   input  wire logic                        open_button,
   input  wire logic                        close_button,
   input  wire logic                        ext_open_req,
   input  wire logic                        ext_close_req,
   input  wire logic                        tool_active,
   input  wire logic                        tool_inputs_off,
   input  wire logic                        pos_known,
   input  wire logic                        at_closed,
   input  wire logic                        at_open,
   input  wire logic                        learn_step_done,
   input  wire logic [3:0]                  stored_force,
   output logic                             normal_op,
   output door_svc_pkg::move_t              move_cmd,
   output logic                             creep_speed,
   output door_svc_pkg::learn_phase_t       learn_phase,
   output logic                             learn_store,
   output logic                             force_store,
   output logic [3:0]                       force_level,
   output logic [9:0]                       force_newton,
   output logic [4:0]                       status_digit_display,
   output logic                             status_dot
);
   typedef enum logic [2:0] {
      M_BOOT, M_SPLASH, M_RELEASE, M_NORMAL, M_LEARN, M_CANCELLED, M_EDIT, M_FORCE
   } mode_t;

   typedef struct packed {
      mode_t        mode;
      learn_phase_t phase;
      logic [1:0]   creep_n;
      logic         learned;
      logic [27:0]  tmr;
      logic [24:0]  blink;
      logic         blink_f;
      logic [3:0]   lvl;
      logic         dot;
      logic         stored;
      logic         lstore;
      logic         fstore;
      logic [4:0]   disp;
      logic [1:0]   move;
   } ctl_t;

   ctl_t st_ff;
   ctl_t nxt_st;
   button_if btn ();
   logic ext_open;
   logic ext_close;
   logic want_open;
   logic want_close;
   logic [1:0] manual_dir;

   button_cond #(
      .DEB_CYC (DEB_CYC)
   ) u_cond (
      .clk  (clk),
      .rst  (rst),
      .pins ({close_button, open_button, learn_button}),
      .btn  (btn)
   );

   // External requests are dropped while the tool is active and has its inputs switched off
   assign ext_open  = ext_open_req  & ~(tool_active & tool_inputs_off);
   assign ext_close = ext_close_req & ~(tool_active & tool_inputs_off);

   // Buttons first, then signals; close wins any tie
   always_comb begin
      want_open  = btn.level[1] | ((~btn.level[1] & ~btn.level[2]) & ext_open);
      want_close = btn.level[2] | ((~btn.level[1] & ~btn.level[2]) & ext_close);
      if (want_close) begin
         manual_dir = 2'(MOVE_CLOSE);
      end else if (want_open & ~at_open) begin
         manual_dir = 2'(MOVE_OPEN);
      end else begin
         manual_dir = 2'(MOVE_STOP);
      end
      if (want_close & at_closed & ~btn.level[1]) begin
         manual_dir = 2'(MOVE_STOP);
      end
   end

   // Main mode sequencer
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.lstore = 1'b0;
      nxt_st.fstore = 1'b0;
      nxt_st.move   = 2'(MOVE_STOP);
      // Free-running blink for alternating displays
      if (st_ff.blink >= 25'(BLINK_LEN - 1)) begin
         nxt_st.blink   = 25'h000_0000;
         nxt_st.blink_f = ~st_ff.blink_f;
      end else begin
         nxt_st.blink = st_ff.blink + 25'h000_0001;
      end
      case (st_ff.mode)
         // Wait two debounce windows plus a few cycles so held buttons are seen
         M_BOOT: begin
            nxt_st.disp = DISP_BLANK;
            nxt_st.tmr  = st_ff.tmr + 28'h000_0001;
            if (st_ff.tmr >= 28'(2 * DEB_CYC + 4)) begin
               nxt_st.tmr = 28'h000_0000;
               if (btn.level[1] & btn.level[2]) begin
                  nxt_st.mode = M_SPLASH;
               end else begin
                  nxt_st.mode = M_NORMAL;
               end
            end
         end
         // Show 8 for the confirm period
         M_SPLASH: begin
            nxt_st.disp = DISP_EIGHT;
            nxt_st.tmr  = st_ff.tmr + 28'h000_0001;
            if (st_ff.tmr >= 28'(SPLASH_LEN - 1)) begin
               nxt_st.tmr  = 28'h000_0000;
               nxt_st.mode = M_RELEASE;
            end
         end
         // Blank; both buttons must be let go in the window
         M_RELEASE: begin
            nxt_st.disp = DISP_BLANK;
            nxt_st.tmr  = st_ff.tmr + 28'h000_0001;
            if (st_ff.tmr >= 28'(RELEASE_LEN - 1)) begin
               nxt_st.tmr = 28'h000_0000;
               if (~btn.level[1] & ~btn.level[2]) begin
                  nxt_st.mode = M_EDIT;
                  nxt_st.lvl  = stored_force;
               end else begin
                  nxt_st.mode = M_NORMAL;
               end
            end
         end
         // Normal service, also the pre-learn positioning state
         M_NORMAL: begin
            nxt_st.disp = st_ff.learned ? DISP_ZERO : (pos_known ? DISP_P : DISP_UNDER);
            if (st_ff.learned || st_ff.disp == DISP_UNDER || st_ff.disp == DISP_P) begin
               nxt_st.move = manual_dir;
            end
            if (btn.level[0]) begin
               nxt_st.tmr = st_ff.tmr + 28'h000_0001;
            end else begin
               nxt_st.tmr = 28'h000_0000;
            end
            if (btn.level[0] && st_ff.tmr >= 28'(LEARN_CYC - 1)) begin
               nxt_st.tmr     = 28'h000_0000;
               nxt_st.mode    = M_LEARN;
               nxt_st.phase   = LR_CREEP_CLOSE;
               nxt_st.creep_n = 2'h0;
               nxt_st.learned = 1'b0;
            end
         end
         // Learn run phases; the drive reports each step done
         M_LEARN: begin
            nxt_st.disp = DISP_H;
            if (btn.press[1] | btn.press[2]) begin
               nxt_st.mode  = M_CANCELLED;
               nxt_st.phase = LR_IDLE;
            end else if (btn.press[0]) begin
               nxt_st.mode  = M_CANCELLED;
               nxt_st.phase = LR_IDLE;
            end else if (learn_step_done) begin
               case (st_ff.phase)
                  LR_CREEP_CLOSE: begin
                     nxt_st.creep_n = st_ff.creep_n + 2'h1;
                     if (at_closed || st_ff.creep_n == 2'h1) begin
                        nxt_st.phase = LR_WIDTH;
                     end
                  end
                  LR_WIDTH: nxt_st.phase = LR_MASS;
                  LR_MASS: nxt_st.phase = LR_STORE;
                  LR_STORE: begin
                     if (at_closed) begin
                        nxt_st.lstore  = 1'b1;
                        nxt_st.learned = 1'b1;
                        nxt_st.phase   = LR_IDLE;
                        nxt_st.mode    = M_NORMAL;
                     end
                  end
                  default: nxt_st.phase = LR_IDLE;
               endcase
            end
         end
         // Only the start of a new learn run (learn hold) or reset leaves here
         M_CANCELLED: begin
            nxt_st.disp = DISP_CANCEL;
            nxt_st.move = manual_dir;
            if (btn.level[0]) begin
               nxt_st.tmr = st_ff.tmr + 28'h000_0001;
            end else begin
               nxt_st.tmr = 28'h000_0000;
            end
            if (btn.level[0] && st_ff.tmr >= 28'(LEARN_CYC - 1)) begin
               nxt_st.tmr     = 28'h000_0000;
               nxt_st.mode    = M_LEARN;
               nxt_st.phase   = LR_CREEP_CLOSE;
               nxt_st.creep_n = 2'h0;
            end
         end
         // Editor top: F and current level alternate
         M_EDIT: begin
            nxt_st.disp = st_ff.blink_f ? {1'b0, st_ff.lvl} : DISP_F;
            if (btn.press[0]) begin
               nxt_st.mode = M_FORCE;
               nxt_st.tmr  = 28'h000_0000;
               nxt_st.dot  = 1'b0;
            end
         end
         // Force setting; no way out except power cycle
         M_FORCE: begin
            nxt_st.disp = st_ff.blink_f ? {1'b0, st_ff.lvl} : DISP_F;
            if (btn.press[1] && st_ff.lvl != FORCE_MIN) begin
               nxt_st.lvl = st_ff.lvl - 4'h1;
               nxt_st.dot = 1'b0;
            end else if (btn.press[2] && st_ff.lvl != FORCE_MAX) begin
               nxt_st.lvl = st_ff.lvl + 4'h1;
               nxt_st.dot = 1'b0;
            end
            if (btn.level[0]) begin
               nxt_st.tmr = st_ff.tmr + 28'h000_0001;
            end else begin
               nxt_st.tmr    = 28'h000_0000;
               nxt_st.stored = 1'b0;
            end
            if (btn.level[0] && !st_ff.stored && st_ff.tmr >= 28'(STORE_CYC)) begin
               nxt_st.fstore = 1'b1;
               nxt_st.dot    = 1'b1;
               nxt_st.stored = 1'b1;
            end
         end
         default: nxt_st.mode = M_BOOT;
      endcase
   end

   // Only reset returns to boot, so the editor persists to power cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '{mode: M_BOOT, phase: LR_IDLE, lvl: FORCE_RST, disp: DISP_BLANK,
                    default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Learn run drives its own moves; creep except mass phase
   always_comb begin
      if (st_ff.mode == M_LEARN) begin
         move_cmd    = (st_ff.phase == LR_STORE) ? MOVE_CLOSE : MOVE_OPEN;
         creep_speed = (st_ff.phase != LR_MASS);
      end else begin
         move_cmd    = move_t'(st_ff.move);
         creep_speed = ~st_ff.learned;
      end
   end

   assign normal_op            = (st_ff.mode == M_NORMAL) & st_ff.learned;
   assign learn_phase          = st_ff.phase;
   assign learn_store          = st_ff.lstore;
   assign force_store          = st_ff.fstore;
   assign force_level          = st_ff.lvl;
   assign force_newton         = 10'(FORCE_BASE_N) + 10'(st_ff.lvl) * 10'(FORCE_STEP_N);
   assign status_digit_display = st_ff.disp;
   assign status_dot           = st_ff.dot;
endmodule
`default_nettype wire

//--- hw/door_svc_pkg.sv
// Shared constants and types for the door service button control block.
// Assumes a 20 MHz system clock; all times are converted to cycles here.
package door_svc_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   // Times in milliseconds as specified
   localparam int unsigned LEARN_HOLD_MS = 3000;
   localparam int unsigned STORE_HOLD_MS = 2000;
   localparam int unsigned SPLASH_MS     = 5000;
   localparam int unsigned RELEASE_MS    = 3000;
   localparam int unsigned BLINK_MS      = 500;
   localparam int unsigned DEBOUNCE_MS   = 20;
   // Cycle counts derived from the times (exact multiples at 20 MHz)
   localparam int unsigned LEARN_HOLD_CYC = (LEARN_HOLD_MS * (CLK_HZ / 1000));
   localparam int unsigned STORE_HOLD_CYC = (STORE_HOLD_MS * (CLK_HZ / 1000));
   localparam int unsigned SPLASH_CYC     = (SPLASH_MS * (CLK_HZ / 1000));
   localparam int unsigned RELEASE_CYC    = (RELEASE_MS * (CLK_HZ / 1000));
   localparam int unsigned BLINK_CYC      = (BLINK_MS * (CLK_HZ / 1000));
   localparam int unsigned DEBOUNCE_CYC   = (DEBOUNCE_MS * (CLK_HZ / 1000));
   // Force level: F = 70 N + x * 30 N, x in 0..9
   localparam logic [3:0]  FORCE_MAX      = 4'h9;
   localparam logic [3:0]  FORCE_MIN      = 4'h0;
   localparam logic [3:0]  FORCE_RST      = 4'h0;
   localparam int unsigned FORCE_BASE_N   = 70;
   localparam int unsigned FORCE_STEP_N   = 30;
   // Display character codes (seven-segment decoder lives outside)
   localparam logic [4:0]  DISP_BLANK     = 5'h1_0;
   localparam logic [4:0]  DISP_UNDER     = 5'h1_1;
   localparam logic [4:0]  DISP_P         = 5'h1_2;
   localparam logic [4:0]  DISP_H         = 5'h1_3;
   localparam logic [4:0]  DISP_F         = 5'h1_4;
   localparam logic [4:0]  DISP_EIGHT     = 5'h0_8;
   localparam logic [4:0]  DISP_ZERO      = 5'h0_0;
   localparam logic [4:0]  DISP_CANCEL    = 5'h1_5;
   // Learn run phases
   typedef enum logic [2:0] {
      LR_IDLE, LR_CREEP_CLOSE, LR_WIDTH, LR_MASS, LR_STORE
   } learn_phase_t;
   // Motion command to the drive
   typedef enum logic [1:0] {
      MOVE_STOP, MOVE_OPEN, MOVE_CLOSE
   } move_t;
endpackage

//--- hw/button_if.sv
// Debounced, synchronised service button levels and press pulses.
// Driven by the button conditioner, read by the control top.
`timescale 1ns/1ps
`default_nettype none
interface button_if;
   logic [2:0] level;   // 0 learn, 1 open, 2 close
   logic [2:0] press;   // One-cycle pulse on each new press
   modport src (output level, output press);
   modport dst (input level, input press);
endinterface
`default_nettype wire

//--- hw/button_cond.sv
// Synchroniser and debouncer for the three service buttons.
// Assumes raw pins asynchronous to clk, active high when pressed.
`timescale 1ns/1ps
`default_nettype none
module button_cond
   import door_svc_pkg::*;
#(
   parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] pins,
   button_if.src           btn
);
   typedef struct packed {
      logic [2:0]  s1;
      logic [2:0]  s2;
      logic [2:0]  lvl;
      logic [2:0]  prs;
      logic [2:0][19:0] cnt;
   } cond_t;

   cond_t st_ff;
   cond_t nxt_st;

   // Level holds until the synced level stays different long enough
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.s1  = pins;
      nxt_st.s2  = st_ff.s1;
      nxt_st.prs = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (st_ff.s2[i] == st_ff.lvl[i]) begin
            nxt_st.cnt[i] = 20'h0_0000;
         end else if (st_ff.cnt[i] >= 20'(DEB_CYC - 1)) begin
            nxt_st.cnt[i] = 20'h0_0000;
            nxt_st.lvl[i] = st_ff.s2[i];
            nxt_st.prs[i] = st_ff.s2[i];
         end else begin
            nxt_st.cnt[i] = st_ff.cnt[i] + 20'h0_0001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign btn.level = st_ff.lvl;
   assign btn.press = st_ff.prs;
endmodule
`default_nettype wire

//--- tb/door_svc_checker_props.sv
// Concurrent checks on the service button block, bound to its top ports.
// Assumes the shortened timers of the bench and debounced levels within 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module door_svc_checker #(
   parameter int unsigned LEARN_CYC = 50
) (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        learn_button,
   input wire logic                        open_button,
   input wire logic                        close_button,
   input wire logic                        ext_open_req,
   input wire logic                        ext_close_req,
   input wire logic                        at_closed,
   input wire logic                        normal_op,
   input wire door_svc_pkg::move_t         move_cmd,
   input wire door_svc_pkg::learn_phase_t  learn_phase,
   input wire logic                        learn_store,
   input wire logic                        force_store,
   input wire logic [3:0]                  force_level,
   input wire logic [9:0]                  force_newton,
   input wire logic [4:0]                  status_digit_display,
   input wire logic                        status_dot
);
   import door_svc_pkg::*;
   logic [7:0] held_ff;
   logic [7:0] nxt_held;
   // Raw learn hold length; saturates so a long hold never wraps
   always_comb begin
      nxt_held = 8'h00;
      if (learn_button) begin
         nxt_held = (held_ff == 8'hff) ? held_ff : held_ff + 8'h01;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held_ff <= 8'h00;
      end else begin
         held_ff <= nxt_held;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Learn run entry and abort, as seen on the phase output
   sequence s_start;
      learn_phase == LR_IDLE ##1 learn_phase == LR_CREEP_CLOSE;
   endsequence
   sequence s_cancel;
      learn_phase inside {LR_CREEP_CLOSE, LR_WIDTH, LR_MASS} ##1 learn_phase == LR_IDLE;
   endsequence
   a_learn_hold_start: assert property (s_start |-> held_ff >= 8'(LEARN_CYC)
      ##[0:1] status_digit_display == DISP_H) else $error("learn run start without hold");
   a_cancel_blocks: assert property (s_cancel |=> !normal_op [*8])
      else $error("normal operation after cancel");
   a_store_cause: assert property (learn_store |-> $past(learn_phase) == LR_STORE
      && $past(at_closed)) else $error("learn store outside closed end");
   a_store_normal: assert property (learn_store |-> ##[0:2] normal_op)
      else $error("no normal operation after learn store");
   a_newton_map: assert property (force_newton == 10'(FORCE_BASE_N + FORCE_STEP_N * force_level))
      else $error("force in newton mismatch");
   a_level_range: assert property (force_level <= FORCE_MAX) else $error("level beyond 9");
   a_dot_on_store: assert property (force_store |-> ##[0:1] status_dot ##1 !force_store)
      else $error("store without dot or long pulse");
   a_tie_close: assert property ((open_button && close_button && learn_phase == LR_IDLE) [*8]
      |-> move_cmd != MOVE_OPEN) else $error("opening with both buttons held");
   a_idle_stops: assert property ((!open_button && !close_button && !ext_open_req
      && !ext_close_req && learn_phase == LR_IDLE) [*8] |-> move_cmd == MOVE_STOP)
      else $error("moving with no request");
   a_button_wins: assert property ((normal_op && close_button && !open_button
      && !at_closed) [*8] |-> move_cmd == MOVE_CLOSE) else $error("close button overridden");
endmodule
`default_nettype wire

//--- tb/door_operator.sv
// Operator model: three push buttons changed only at falling clock edges.
// Assumes pull-downs on the pins, so a released button reads low.
`timescale 1ns/1ps
`default_nettype none
module door_operator (
   input  wire logic clk,
   output logic      learn_button,
   output logic      open_button,
   output logic      close_button
);
   logic [2:0] pins = 3'b000;
   // Bit 0 learn, bit 1 open, bit 2 close
   assign learn_button = pins[0];
   assign open_button  = pins[1];
   assign close_button = pins[2];
   // Hold a button set for n cycles; the set stays on the pins until the next call
   task automatic drive(input logic [2:0] m, input int n);
      pins = m;
      repeat (n) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- tb/door_service_button_control_tb_top.sv
// Self-checking bench for the service button block with an operator model.
// Assumes shortened timers; inputs change at falling edges only.
`timescale 1ns/1ps
`default_nettype none
module door_service_button_control_tb_top;
   import door_svc_pkg::*;
   localparam int unsigned LCYC = 50;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         ext_open_req = 1'b0;
   logic         ext_close_req = 1'b0;
   logic         tool_active = 1'b0;
   logic         tool_inputs_off = 1'b0;
   logic         pos_known = 1'b0;
   logic         at_closed = 1'b0;
   logic         at_open = 1'b0;
   logic         learn_step_done = 1'b0;
   logic [3:0]   stored_force = 4'h0;
   wire logic    learn_button;
   wire logic    open_button;
   wire logic    close_button;
   logic         normal_op;
   move_t        move_cmd;
   logic         creep_speed;
   learn_phase_t learn_phase;
   logic         learn_store;
   logic         force_store;
   logic [3:0]   force_level;
   logic [9:0]   force_newton;
   logic [4:0]   status_digit_display;
   logic         status_dot;
   int           num_errors = 0;
   int           checks = 0;

   always #25 clk = ~clk;

   door_operator i_op (.clk(clk), .learn_button(learn_button), .open_button(open_button),
      .close_button(close_button));
   door_service_button_control #(.LEARN_CYC(LCYC), .STORE_CYC(40), .SPLASH_LEN(30),
      .RELEASE_LEN(30), .BLINK_LEN(8), .DEB_CYC(2)) i_dut (.clk(clk), .rst(rst),
      .learn_button(learn_button), .open_button(open_button), .close_button(close_button),
      .ext_open_req(ext_open_req), .ext_close_req(ext_close_req), .tool_active(tool_active),
      .tool_inputs_off(tool_inputs_off), .pos_known(pos_known), .at_closed(at_closed),
      .at_open(at_open), .learn_step_done(learn_step_done), .stored_force(stored_force),
      .normal_op(normal_op), .move_cmd(move_cmd), .creep_speed(creep_speed),
      .learn_phase(learn_phase), .learn_store(learn_store), .force_store(force_store),
      .force_level(force_level), .force_newton(force_newton),
      .status_digit_display(status_digit_display), .status_dot(status_dot));

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait for a display code; a timeout shows up as a mismatch
   task automatic wait_disp(input logic [4:0] code);
      int n;
      n = 0;
      while (status_digit_display !== code && n < 200) begin
         @(negedge clk);
         n++;
      end
      check(10'(status_digit_display), 10'(code));
   endtask
   task automatic step();
      learn_step_done = 1'b1;
      tick(1);
      learn_step_done = 1'b0;
      tick(3);
   endtask
   task automatic start_learn();
      i_op.drive(3'b001, LCYC + 15);
      i_op.drive(3'b000, 10);
      check(10'(learn_phase), 10'(LR_CREEP_CLOSE));
      check(10'(status_digit_display), 10'(DISP_H));
   endtask
   task automatic t_manual();
      check(10'(status_digit_display), 10'(DISP_UNDER));
      i_op.drive(3'b010, 10);
      check(10'(move_cmd), 10'(MOVE_OPEN));
      i_op.drive(3'b110, 10);
      check(10'(move_cmd), 10'(MOVE_CLOSE));
      i_op.drive(3'b000, 10);
      check(10'(move_cmd), 10'(MOVE_STOP));
      pos_known = 1'b1;
      tick(3);
      check(10'(status_digit_display), 10'(DISP_P));
   endtask
   // Full run; the last step report is given with the door already at the closed end
   task automatic t_learn();
      logic got;
      got = 1'b0;
      at_closed = 1'b1;
      start_learn();
      at_closed = 1'b0;
      check(10'(creep_speed), 10'd1);
      step();
      step();
      check(10'(learn_phase), 10'(LR_WIDTH));
      step();
      check(10'(learn_phase), 10'(LR_MASS));
      check(10'(creep_speed), 10'd0);
      step();
      check(10'(learn_phase), 10'(LR_STORE));
      at_closed = 1'b1;
      // Store needs the drive's last step report at the closed end
      learn_step_done = 1'b1;
      repeat (10) begin
         @(negedge clk);
         learn_step_done = 1'b0;
         if (learn_store === 1'b1) got = 1'b1;
      end
      check(10'(got), 10'd1);
      check(10'(normal_op), 10'd1);
   endtask
   task automatic t_override();
      at_closed = 1'b0;
      ext_open_req = 1'b1;
      tick(5);
      check(10'(move_cmd), 10'(MOVE_OPEN));
      i_op.drive(3'b100, 10);
      check(10'(move_cmd), 10'(MOVE_CLOSE));
      i_op.drive(3'b000, 10);
      ext_close_req = 1'b1;
      tick(5);
      check(10'(move_cmd), 10'(MOVE_CLOSE));
      tool_active = 1'b1;
      tool_inputs_off = 1'b1;
      tick(5);
      check(10'(move_cmd), 10'(MOVE_STOP));
      {ext_open_req, ext_close_req, tool_active, tool_inputs_off} = 4'h0;
      at_closed = 1'b1;
   endtask
   task automatic t_cancel();
      start_learn();
      i_op.drive(3'b010, 10);
      check(10'(learn_phase), 10'(LR_IDLE));
      i_op.drive(3'b000, 10);
      start_learn();
      i_op.drive(3'b001, 10);
      check(10'(learn_phase), 10'(LR_IDLE));
      i_op.drive(3'b000, 20);
      check(10'(normal_op), 10'd0);
   endtask
   // Power-up entry with both buttons, level edits with saturation, store
   task automatic t_editor();
      int first;
      first = 0;
      stored_force = 4'h3;
      rst = 1'b1;
      i_op.drive(3'b110, 5);
      rst = 1'b0;
      wait_disp(DISP_EIGHT);
      wait_disp(DISP_BLANK);
      i_op.drive(3'b000, 5);
      wait_disp(DISP_F);
      wait_disp(DISP_ZERO + 5'h03);
      i_op.drive(3'b001, 4);
      i_op.drive(3'b000, 6);
      wait_disp(DISP_F);
      for (int i = 0; i < 7; i++) begin
         i_op.drive(3'b100, 4);
         i_op.drive(3'b000, 6);
      end
      check(10'(force_level), 10'd9);
      for (int i = 0; i < 10; i++) begin
         i_op.drive(3'b010, 4);
         i_op.drive(3'b000, 6);
      end
      check(10'(force_level), 10'd0);
      i_op.drive(3'b100, 4);
      i_op.drive(3'b000, 6);
      check(10'(force_newton), 10'd100);
      i_op.drive(3'b001, 0);
      for (int i = 1; i <= 60; i++) begin
         @(negedge clk);
         if (force_store === 1'b1 && first == 0) first = i;
      end
      i_op.drive(3'b000, 10);
      check(10'(first > 40), 10'd1);
      check(10'(status_dot), 10'd1);
      check(10'(learn_phase), 10'(LR_IDLE));
      check(10'(normal_op), 10'd0);
      wait_disp(DISP_F);
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      tick(3);
      rst = 1'b0;
      tick(20);
      t_manual();
      t_learn();
      t_override();
      t_cancel();
      t_learn();
      t_editor();
      end_of_test();
   end
   // Watchdog far beyond the thousand or so cycles the scenarios need
   initial begin
      tick(20000);
      num_errors++;
      end_of_test();
   end
endmodule

bind door_service_button_control door_svc_checker #(.LEARN_CYC(LEARN_CYC)) i_chk (
   .clk(clk), .rst(rst), .learn_button(learn_button), .open_button(open_button),
   .close_button(close_button), .ext_open_req(ext_open_req), .ext_close_req(ext_close_req),
   .at_closed(at_closed), .normal_op(normal_op), .move_cmd(move_cmd),
   .learn_phase(learn_phase), .learn_store(learn_store), .force_store(force_store),
   .force_level(force_level), .force_newton(force_newton),
   .status_digit_display(status_digit_display), .status_dot(status_dot));
`default_nettype wire
